// ==== uepc_defs.svh ====
// Timing constants and field widths for the EPROM programming controller
`ifndef UEPC_DEFS_SVH
`define UEPC_DEFS_SVH

`define UEPC_CLK_PERIOD_PS     5000
`define UEPC_ADDR_W            11
`define UEPC_DATA_W            8
`define UEPC_ERASED_BYTE       8'hff
// Program pulse width, least and longest, in microseconds
`define UEPC_PULSE_MIN_US      45000
`define UEPC_PULSE_MAX_US      55000
// Nominal pulse sits between the two limits
`define UEPC_PULSE_NOM_US      50000
// Setup and hold around the pulse, in microseconds
`define UEPC_SETUP_US          2
`define UEPC_HOLD_US           2
// Read access wait, in nanoseconds
`define UEPC_ACCESS_NS         450
// Microsecond tick: 1000000 ps / period
`define UEPC_US_CYCLES         (1000000 / `UEPC_CLK_PERIOD_PS)
`define UEPC_ACCESS_CYCLES     ((`UEPC_ACCESS_NS * 1000 + `UEPC_CLK_PERIOD_PS - 1) / `UEPC_CLK_PERIOD_PS)

`endif

// ==== uepc_pkg.sv ====
// Types shared by the EPROM programming controller
package uepc_pkg;
    typedef enum logic [1:0]
    {
        UEPC_OP_READ,
        UEPC_OP_PROGRAM,
        UEPC_OP_PROGRAM_VERIFY,
        UEPC_OP_STANDBY
    } uepc_op_t;
endpackage

// ==== uepc_us_tick.sv ====
// Divider that produces a one-cycle enable once per microsecond
`timescale 1ns/100ps
`default_nettype none
`include "uepc_defs.svh"

module uepc_us_tick
#(
    parameter int DIVIDE = `UEPC_US_CYCLES
)
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Tick out
    output var  logic tick
);
    localparam int CW = $clog2(DIVIDE + 1);

    logic [CW-1:0] countReg;

    if (DIVIDE < 2)
    begin : g_bad_divide
        $error("uepc_us_tick: DIVIDE must be at least 2");
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            countReg <= '0;
            tick     <= 1'b0;
        end
        else if (countReg == CW'(DIVIDE - 1))
        begin
            countReg <= '0;
            tick     <= 1'b1;
        end
        else
        begin
            countReg <= countReg + 1'b1;
            tick     <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== uepc_controller.sv ====
// Host-side controller that reads, programs and verifies a UV EPROM over its pins
`timescale 1ns/100ps
`default_nettype none
`include "uepc_defs.svh"

module uepc_controller
    import uepc_pkg::*;
#(
    parameter int ADDR_W       = `UEPC_ADDR_W,
    parameter int DATA_W       = `UEPC_DATA_W,
    parameter int DEVICES      = 1,
    parameter int PULSE_US     = `UEPC_PULSE_NOM_US,
    parameter int PULSE_MAX_US = `UEPC_PULSE_MAX_US,
    parameter int PULSE_MIN_US = `UEPC_PULSE_MIN_US,
    parameter int US_CYCLES    = `UEPC_US_CYCLES
)
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // Command port
    input  wire logic              cmdValid,
    input  wire uepc_op_t          cmdOp,
    input  wire logic [ADDR_W-1:0] cmdAddr,
    input  wire logic [DATA_W-1:0] cmdData,
    input  wire logic [DEVICES-1:0] cmdSelect,
    output var  logic              cmdReady,
    // Answer port
    output var  logic              rspValid,
    output var  logic [DATA_W-1:0] rspData,
    output var  logic              rspMismatch,
    // Memory pins
    output var  logic [ADDR_W-1:0] memAddr,
    input  wire logic [DATA_W-1:0] memDataIn,
    output var  logic [DATA_W-1:0] memDataOut,
    output var  logic              memDataOen,
    output var  logic [DEVICES-1:0] enable_program_n,
    output var  logic              outputEnable_n,
    output var  logic              progSupplyHigh
);
    localparam int SETUP_TICKS  = `UEPC_SETUP_US;
    localparam int HOLD_TICKS   = `UEPC_HOLD_US;
    localparam int ACCESS_CYC   = `UEPC_ACCESS_CYCLES;
    // One timer serves both the pulse and the access wait, so it must hold the longer
    localparam int TMAX         = (PULSE_MAX_US > ACCESS_CYC) ? PULSE_MAX_US : ACCESS_CYC;
    localparam int TW           = $clog2(TMAX + 1);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (PULSE_US < PULSE_MIN_US || PULSE_US > PULSE_MAX_US)
    begin : g_bad_pulse
        $error("uepc_controller: PULSE_US outside pulse limits");
    end
    if (DEVICES < 1 || ACCESS_CYC > US_CYCLES)
    begin : g_bad_rate
        $error("uepc_controller: bad DEVICES or clock rate");
    end

    typedef enum logic [2:0]
    {
        UEPC_IDLE,
        UEPC_READ_WAIT,
        UEPC_PROG_SETUP,
        UEPC_PROG_PULSE,
        UEPC_PROG_HOLD,
        UEPC_VERIFY_WAIT
    } uepc_state_t;

    uepc_state_t   stateReg;
    logic [TW-1:0] timerReg;
    logic          tick;
    logic [DEVICES-1:0] selReg;
    uepc_op_t           opReg;
    logic [DATA_W-1:0]  wrDataReg;

    // ------------------------------------------------------------
    // Microsecond enable
    // ------------------------------------------------------------
    uepc_us_tick
    #(
        .DIVIDE (US_CYCLES)
    )
    uTick
    (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            stateReg <= UEPC_IDLE;
            timerReg <= '0;
            selReg   <= '0;
        end
        else
        begin
            unique case (stateReg)
                UEPC_IDLE:
                begin
                    timerReg <= '0;
                    if (cmdValid)
                    begin
                        selReg <= cmdSelect;
                        unique case (cmdOp)
                            UEPC_OP_PROGRAM:        stateReg <= UEPC_PROG_SETUP;
                            UEPC_OP_PROGRAM_VERIFY: stateReg <= UEPC_PROG_SETUP;
                            UEPC_OP_READ:           stateReg <= UEPC_READ_WAIT;
                            UEPC_OP_STANDBY:        stateReg <= UEPC_IDLE;
                        endcase
                    end
                end
                UEPC_READ_WAIT, UEPC_VERIFY_WAIT:
                begin
                    // Counted in system cycles; access is well under one microsecond
                    if (timerReg == TW'(ACCESS_CYC))
                        stateReg <= UEPC_IDLE;
                    else
                        timerReg <= timerReg + 1'b1;
                end
                UEPC_PROG_SETUP:
                begin
                    // address and data stable before pulse
                    // First tick may come at once, so one extra tick keeps the full setup
                    if (tick)
                    begin
                        if (timerReg == TW'(SETUP_TICKS))
                        begin
                            stateReg <= UEPC_PROG_PULSE;
                            timerReg <= '0;
                        end
                        else
                            timerReg <= timerReg + 1'b1;
                    end
                end
                UEPC_PROG_PULSE:
                begin
                    // hard stop at the configured width, never past maximum
                    if (tick)
                    begin
                        if (timerReg == TW'(PULSE_US - 1))
                        begin
                            stateReg <= UEPC_PROG_HOLD;
                            timerReg <= '0;
                        end
                        else
                            timerReg <= timerReg + 1'b1;
                    end
                end
                UEPC_PROG_HOLD:
                begin
                    if (tick)
                    begin
                        if (timerReg == TW'(HOLD_TICKS - 1))
                        begin
                            timerReg <= '0;
                            stateReg <= (opReg == UEPC_OP_PROGRAM_VERIFY) ?
                                        UEPC_VERIFY_WAIT : UEPC_IDLE;
                        end
                        else
                            timerReg <= timerReg + 1'b1;
                    end
                end
                default: stateReg <= UEPC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Command capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            opReg      <= UEPC_OP_STANDBY;
            wrDataReg  <= `UEPC_ERASED_BYTE;
            memAddr    <= '0;
            cmdReady   <= 1'b0;
        end
        else
        begin
            cmdReady <= (stateReg == UEPC_IDLE) && !cmdValid;
            if (stateReg == UEPC_IDLE && cmdValid)
            begin
                opReg     <= cmdOp;
                wrDataReg <= cmdData;
                memAddr   <= cmdAddr;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Outputs float (oen high) except while a byte is presented for programming.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            enable_program_n <= '1;
            outputEnable_n   <= 1'b1;
            progSupplyHigh   <= 1'b0;
            memDataOut       <= '0;
            memDataOen       <= 1'b1;
        end
        else
        begin
            unique case (stateReg)
                UEPC_PROG_SETUP, UEPC_PROG_HOLD:
                begin
                    // oe high, pin low, supply raised, data driven
                    // deselected memories float while oe is high
                    outputEnable_n   <= 1'b1;
                    enable_program_n <= '0;
                    progSupplyHigh   <= 1'b1;
                    memDataOut       <= wrDataReg;
                    memDataOen       <= 1'b0;
                end
                UEPC_PROG_PULSE:
                begin
                    // unselected memories see no pulse
                    // Selected pins rise; the rest stay low, inhibited
                    outputEnable_n   <= 1'b1;
                    enable_program_n <= selReg;
                    progSupplyHigh   <= 1'b1;
                    memDataOut       <= wrDataReg;
                    memDataOen       <= 1'b0;
                end
                UEPC_VERIFY_WAIT:
                begin
                    // both enables low, supply kept raised
                    outputEnable_n   <= 1'b0;
                    enable_program_n <= ~selReg;
                    progSupplyHigh   <= 1'b1;
                    memDataOen       <= 1'b1;
                end
                UEPC_READ_WAIT:
                begin
                    // both enables low for a read
                    outputEnable_n   <= 1'b0;
                    enable_program_n <= ~selReg;
                    progSupplyHigh   <= 1'b0;
                    memDataOen       <= 1'b1;
                end
                default:
                begin
                    outputEnable_n   <= 1'b1;
                    enable_program_n <= '1;
                    progSupplyHigh   <= 1'b0;
                    memDataOen       <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    logic accessDone;
    assign accessDone = (stateReg == UEPC_READ_WAIT || stateReg == UEPC_VERIFY_WAIT)
                        && timerReg == TW'(ACCESS_CYC);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            rspValid    <= 1'b0;
            rspData     <= `UEPC_ERASED_BYTE;
            rspMismatch <= 1'b0;
        end
        else
        begin
            rspValid <= accessDone ||
                        (stateReg == UEPC_PROG_HOLD && tick &&
                         timerReg == TW'(HOLD_TICKS - 1) && opReg == UEPC_OP_PROGRAM);
            if (accessDone)
            begin
                rspData     <= memDataIn;
                rspMismatch <= (stateReg == UEPC_VERIFY_WAIT) && (memDataIn != wrDataReg);
            end
            else if (stateReg == UEPC_PROG_HOLD)
                rspMismatch <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== uepc_ctl_checker.sv ====
// Pin-level assertions for the EPROM programming controller
`timescale 1ns/100ps
`default_nettype none
`include "uepc_defs.svh"
module uepc_ctl_checker
    import uepc_pkg::*;
#(
    parameter int ADDR_W       = `UEPC_ADDR_W,
    parameter int DATA_W       = `UEPC_DATA_W,
    parameter int DEVICES      = 1,
    parameter int PULSE_MAX_US = `UEPC_PULSE_MAX_US,
    parameter int PULSE_MIN_US = `UEPC_PULSE_MIN_US,
    parameter int US_CYCLES    = `UEPC_US_CYCLES
)
(
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               resetn,
    // Command and answer
    input wire logic               cmdValid,
    input wire uepc_op_t           cmdOp,
    input wire logic               cmdReady,
    input wire logic               rspValid,
    // Memory pins
    input wire logic [ADDR_W-1:0]  memAddr,
    input wire logic [DATA_W-1:0]  memDataOut,
    input wire logic               memDataOen,
    input wire logic [DEVICES-1:0] enable_program_n,
    input wire logic               outputEnable_n,
    input wire logic               progSupplyHigh
);
    // ----------------------------------------
    // Pulse width and setup counters
    // ----------------------------------------
    logic pulseOn;
    logic setupOn;
    int   pulseCnt_reg;
    int   setupCnt_reg;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // Verify raises unselected pins with the supply up, so a pulse also needs oe high
    assign pulseOn = progSupplyHigh && outputEnable_n && (|enable_program_n);
    assign setupOn = progSupplyHigh && outputEnable_n && !(|enable_program_n) && !memDataOen;
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !pulseOn)
            pulseCnt_reg <= 0;
        else
            pulseCnt_reg <= pulseCnt_reg + 1;
    end
    always_ff @(posedge sys_clk)
    begin
        if (!resetn || !setupOn)
            setupCnt_reg <= 0;
        else
            setupCnt_reg <= setupCnt_reg + 1;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_pulse_oe_high: assert property ($fell(pulseOn) |->
        (outputEnable_n && progSupplyHigh && !(|enable_program_n)) [*8])
        else $error("output enable or supply dropped right after program pulse");
    a_pulse_drives: assert property (pulseOn |-> !memDataOen)
        else $error("data not driven during program pulse");
    a_pulse_stable: assert property (pulseOn |-> $stable(memAddr) && $stable(memDataOut))
        else $error("address or data moved under program pulse");
    a_pulse_max: assert property (pulseCnt_reg <= PULSE_MAX_US * US_CYCLES)
        else $error("program pulse too long");
    a_pulse_min: assert property ($fell(pulseOn) |-> pulseCnt_reg >= PULSE_MIN_US * US_CYCLES)
        else $error("program pulse too short");
    a_pulse_setup: assert property ($rose(pulseOn) |-> setupCnt_reg >= `UEPC_SETUP_US * US_CYCLES)
        else $error("program pulse started before setup time");
    a_hold_addr: assert property ($fell(pulseOn) |-> ($stable(memAddr) && !memDataOen) [*8])
        else $error("address or data released right after pulse");
    a_read_answer: assert property (cmdValid && cmdReady && cmdOp == UEPC_OP_READ
        |=> ##1 !outputEnable_n ##90 rspValid)
        else $error("read answer not on time");
    a_no_contention: assert property (!outputEnable_n |-> memDataOen)
        else $error("controller drives data while memory outputs enabled");
    a_rsp_pulse: assert property (rspValid |=> !rspValid)
        else $error("answer valid longer than one cycle");
endmodule

bind uepc_controller uepc_ctl_checker #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .DEVICES(DEVICES),
    .PULSE_MAX_US(PULSE_MAX_US),
    .PULSE_MIN_US(PULSE_MIN_US),
    .US_CYCLES(US_CYCLES)
) i_uepc_ctl_checker (.sys_clk, .resetn, .cmdValid, .cmdOp, .cmdReady, .rspValid, .memAddr,
    .memDataOut, .memDataOen, .enable_program_n, .outputEnable_n, .progSupplyHigh);
`default_nettype wire

// ==== uepc_eprom_model.sv ====
// Behavioural model of one UV EPROM as seen at its pins
`timescale 1ns/100ps
`default_nettype none
module uepc_eprom_model
#(
    // Microsecond scaled to the bench's 90-cycle tick; access just under its 90-cycle wait
    parameter int US_NS  = 450,
    parameter int ACC_NS = 445
)
(
    // Pins
    input  wire logic [10:0] addr,
    input  wire logic [7:0]  dataIn,
    input  wire logic        enable_program_n,
    input  wire logic        outputEnable_n,
    input  wire logic        progSupplyHigh,
    // Read drive and bad pulse count
    output var  logic [7:0]  dataOut,
    output var  logic        dataDrive,
    output var  int          faults
);
    logic [7:0]  mem [2048];
    realtime     riseTime;
    logic [10:0] pulseAddr;
    logic [7:0]  pulseData;
    initial
    begin
        foreach (mem[i])
            mem[i] = 8'hff;
        dataOut = 8'h00;
        faults = 0;
        riseTime = 0;
    end
    // drive only when both enables low
    assign dataDrive = !enable_program_n && !outputEnable_n;
    // Garbage until access time passes, so early sampling is caught
    always @(addr, dataDrive)
    begin
        dataOut = ~dataOut;
        dataOut <= #(ACC_NS) mem[addr];
    end
    // pulse counts only with supply raised
    always @(posedge enable_program_n)
    begin
        riseTime = (progSupplyHigh && outputEnable_n) ? $realtime : 0;
        pulseAddr = addr;
        pulseData = dataIn;
    end
    // A rise with the supply down or outputs on is no program pulse
    always @(progSupplyHigh, outputEnable_n)
    begin
        if (!progSupplyHigh || !outputEnable_n)
            riseTime = 0;
    end
    always @(negedge enable_program_n)
    begin
        if (riseTime > 0)
        begin
            if ($realtime - riseTime < 45 * US_NS || $realtime - riseTime > 55 * US_NS
                || addr !== pulseAddr || dataIn !== pulseData)
                faults++;
            else
                mem[addr] = mem[addr] & dataIn;
        end
        riseTime = 0;
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Bench: controller driving two EPROM models
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import uepc_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cmdValid = 1'b0;
    uepc_op_t    cmdOp = UEPC_OP_READ;
    logic [10:0] cmdAddr = 11'h000;
    logic [7:0]  cmdData = 8'h00;
    logic [1:0]  cmdSelect = 2'h1;
    logic        cmdReady, rspValid, rspMismatch, memDataOen, outputEnable_n, progSupplyHigh;
    logic [10:0] memAddr, a;
    logic [7:0]  rspData, memDataOut, memDataIn, dq0, dq1, d, e;
    logic [7:0]  floatVal = 8'h00;
    logic [1:0]  enable_program_n, s;
    wire logic [1:0] drv;
    logic [7:0]  memRef [2][2048];
    logic [10:0] used [$];
    int          faults0, faults1, mismatches = 0, compares = 0, seed = 84;

    always #2.5 sys_clk = ~sys_clk;
    // Undriven bus shows a changing pattern, never a stale byte
    assign memDataIn = !memDataOen ? memDataOut : drv[0] ? dq0 : drv[1] ? dq1 : floatVal;
    always @(posedge sys_clk)
        floatVal <= ~memDataIn;

    uepc_controller #(.DEVICES(2), .PULSE_US(50), .PULSE_MAX_US(55), .PULSE_MIN_US(45),
        .US_CYCLES(90)) i_uepc_controller (.sys_clk, .resetn, .cmdValid, .cmdOp, .cmdAddr,
        .cmdData, .cmdSelect, .cmdReady, .rspValid, .rspData, .rspMismatch, .memAddr,
        .memDataIn, .memDataOut, .memDataOen, .enable_program_n, .outputEnable_n,
        .progSupplyHigh);
    uepc_eprom_model i_uepc_eprom_model_0 (.addr(memAddr),
        .dataIn(memDataIn), .enable_program_n(enable_program_n[0]), .outputEnable_n,
        .progSupplyHigh, .dataOut(dq0), .dataDrive(drv[0]), .faults(faults0));
    uepc_eprom_model i_uepc_eprom_model_1 (.addr(memAddr),
        .dataIn(memDataIn), .enable_program_n(enable_program_n[1]), .outputEnable_n,
        .progSupplyHigh, .dataOut(dq1), .dataDrive(drv[1]), .faults(faults1));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [7:0] progged(input logic [7:0] old, input logic [7:0] da);
        return old & da;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic run(input uepc_op_t op, input logic [10:0] ad, input logic [7:0] da,
                       input logic [1:0] se);
        int n;
        n = 0;
        while (cmdReady !== 1'b1 && n < 50)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({7'h0, cmdReady}, 8'h01);
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdAddr <= ad;
        cmdData <= da;
        cmdSelect <= se;
        @(posedge sys_clk);
        cmdValid <= 1'b0;
        n = 0;
        while (op != UEPC_OP_STANDBY && rspValid !== 1'b1 && n < 6000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (op != UEPC_OP_STANDBY)
            check({7'h0, rspValid}, 8'h01);
    endtask
    task automatic rd(input logic [10:0] ad, input logic [1:0] se);
        run(UEPC_OP_READ, ad, 8'h00, se);
        check(rspData, memRef[se[1]][ad]);
    endtask
    task automatic prog(input uepc_op_t op, input logic [10:0] ad, input logic [7:0] da,
                        input logic [1:0] se);
        for (int k = 0; k < 2; k++)
            if (se[k])
                memRef[k][ad] = progged(memRef[k][ad], da);
        used.push_back(ad);
        run(op, ad, da, se);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        foreach (memRef[i, j])
            memRef[i][j] = 8'hff;
        repeat (20) @(posedge sys_clk);
        check({3'h0, enable_program_n, outputEnable_n, progSupplyHigh, memDataOen}, 8'h1d);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++)
            rd(11'($random(seed)), 2'h1 << ($random(seed) & 1));
        // Corners first: same word twice, then all ones
        for (int i = 0; i < 6; i++)
        begin
            a = (i < 2) ? 11'h000 : (i == 2) ? 11'h7ff : 11'($random(seed));
            d = (i == 0) ? 8'h5a : (i == 1) ? 8'ha5 : (i == 2) ? 8'hff : 8'($random(seed));
            s = (i < 3) ? 2'h1 : 2'h1 << ($random(seed) & 1);
            prog(UEPC_OP_PROGRAM_VERIFY, a, d, s);
            e = memRef[s[1]][a];
            check(rspData, e);
            check({7'h0, rspMismatch}, {7'h0, e != d});
        end
        prog(UEPC_OP_PROGRAM, 11'h3c5, 8'($random(seed)), 2'h3);
        prog(UEPC_OP_PROGRAM, 11'($random(seed)), 8'h0f, 2'h2);
        foreach (used[k])
        begin
            rd(used[k], 2'h1);
            rd(used[k], 2'h2);
        end
        run(UEPC_OP_STANDBY, 11'h000, 8'h00, 2'h3);
        @(negedge sys_clk);
        check({6'h0, enable_program_n}, 8'h03);
        check(8'(faults0 + faults1), 8'h00);
        test_done;
    end
    initial
    begin
        #300000;
        mismatches++;
        test_done;
    end
endmodule
`default_nettype wire
